// ==== src/cgcr_pkg.sv ====
// package with register map constants for the clock generator control bank low part
package cgcr_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_SPCFG = 12'h000;
  localparam logic [11:0] ADDR_RBSEL = 12'h004;
  localparam logic [11:0] ADDR_VER_LO = 12'h005;
  localparam logic [11:0] ADDR_VER_HI = 12'h006;
  localparam logic [11:0] ADDR_PRI_LO = 12'h010;
  localparam logic [11:0] ADDR_PRI_HI = 12'h011;
  localparam logic [11:0] ADDR_SEC_LO = 12'h012;
  localparam logic [11:0] ADDR_SEC_HI = 12'h013;
  localparam logic [11:0] ADDR_TEST = 12'h014;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_DIV = 10'h000;
  localparam logic [15:0] RST_VER = 16'h0000;
  localparam logic [5:0] RST_TEST = 6'h00;
  // serial port config field positions, mirrored pairs
  localparam int SP_SDO_HI = 7;
  localparam int SP_LSB_HI = 6;
  localparam int SP_RST_HI = 5;
  localparam int SP_RST_LO = 2;
  localparam int SP_LSB_LO = 1;
  localparam int SP_SDO_LO = 0;
  localparam int RB_ACTIVE_BIT = 0;
  localparam int TEST_W = 6;
endpackage

// ==== src/cgcr_regs.sv ====
// register bank: serial port config, readback select, version id, reference dividers
// Functional notes
// - writes to addresses outside the map are dropped and change nothing.
// - readback select bit 0 picks active over buffered values on reads, reset zero.
// - the primary divider is 10 bits, 7:0 low address, 9:8 in low bits of next.
// - the secondary divider is 10 bits laid out the same way at the next pair.
`timescale 1ns/100ps
module cgcr_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register access from the serial port
  input wire logic wr_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic i2c_mode_i,
  input wire logic transfer_i,
  output logic [7:0] rdata_o,
  // configuration outputs
  output logic soft_reset_o,
  output logic lsb_first_o,
  output logic sdo_active_o,
  output logic [15:0] version_o,
  output logic [9:0] pri_div_o,
  output logic [9:0] sec_div_o,
  output logic [5:0] test_div_o
);
  logic [2:0] spcfg;
  logic rb_active;
  logic [15:0] ver_buf;
  logic [9:0] pri_buf;
  logic [9:0] sec_buf;
  logic [5:0] test_buf;
  logic [7:0] sp_byte;
  logic hit;

  // a control bit is set if either mirror position is set
  always_comb begin
    sp_byte = cgcr_pkg::RST_BYTE;
    sp_byte[cgcr_pkg::SP_SDO_HI] = spcfg[0];
    sp_byte[cgcr_pkg::SP_SDO_LO] = spcfg[0];
    sp_byte[cgcr_pkg::SP_LSB_HI] = spcfg[1];
    sp_byte[cgcr_pkg::SP_LSB_LO] = spcfg[1];
    sp_byte[cgcr_pkg::SP_RST_HI] = spcfg[2];
    sp_byte[cgcr_pkg::SP_RST_LO] = spcfg[2];
  end

  always_comb begin
    case (addr_i)
      cgcr_pkg::ADDR_SPCFG, cgcr_pkg::ADDR_RBSEL, cgcr_pkg::ADDR_VER_LO,
      cgcr_pkg::ADDR_VER_HI, cgcr_pkg::ADDR_PRI_LO, cgcr_pkg::ADDR_PRI_HI,
      cgcr_pkg::ADDR_SEC_LO, cgcr_pkg::ADDR_SEC_HI, cgcr_pkg::ADDR_TEST: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // serial port config; i2c mode only honours soft reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      spcfg <= 3'h0;
    end else if (wr_i && addr_i == cgcr_pkg::ADDR_SPCFG) begin
      spcfg[2] <= wdata_i[cgcr_pkg::SP_RST_HI] | wdata_i[cgcr_pkg::SP_RST_LO];
      if (!i2c_mode_i) begin
        spcfg[0] <= wdata_i[cgcr_pkg::SP_SDO_HI] | wdata_i[cgcr_pkg::SP_SDO_LO];
        spcfg[1] <= wdata_i[cgcr_pkg::SP_LSB_HI] | wdata_i[cgcr_pkg::SP_LSB_LO];
      end
    end else begin
      spcfg[2] <= 1'b0; // soft reset self clears
    end
  end

  a_soft_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_SPCFG
      && (wdata_i[cgcr_pkg::SP_RST_HI] || wdata_i[cgcr_pkg::SP_RST_LO])) |=> soft_reset_o)
    else $error("soft reset not raised");
  // the soft reset strobe must never stick
  a_soft_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (soft_reset_o && !(wr_i && addr_i == cgcr_pkg::ADDR_SPCFG)) |=> !soft_reset_o)
    else $error("soft reset did not self clear");
  a_i2c_sdo: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_SPCFG && i2c_mode_i) |=> $stable(sdo_active_o))
    else $error("i2c write changed output enable");

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rb_active <= 1'b0;
    end else if (wr_i && addr_i == cgcr_pkg::ADDR_RBSEL) begin
      rb_active <= wdata_i[cgcr_pkg::RB_ACTIVE_BIT];
    end
  end

  a_rbsel_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_RBSEL)
    |=> rb_active == $past(wdata_i[cgcr_pkg::RB_ACTIVE_BIT]))
    else $error("readback select not stored");
  // no disable here: this one watches the reset itself
  a_reset_zero: assert property (@(posedge clk_i)
    !nrst_i |=> !rb_active && rdata_o == 8'h00 && version_o == cgcr_pkg::RST_VER
      && pri_div_o == cgcr_pkg::RST_DIV && sec_div_o == cgcr_pkg::RST_DIV)
    else $error("state not cleared by reset");

  // buffered values; unmapped writes fall through untouched
  always_ff @(posedge clk_i) begin
    if (!nrst_i || spcfg[2]) begin
      ver_buf <= cgcr_pkg::RST_VER;
      pri_buf <= cgcr_pkg::RST_DIV;
      sec_buf <= cgcr_pkg::RST_DIV;
      test_buf <= cgcr_pkg::RST_TEST;
    end else if (wr_i && hit) begin
      case (addr_i)
        cgcr_pkg::ADDR_VER_LO: ver_buf[7:0] <= wdata_i;
        cgcr_pkg::ADDR_VER_HI: ver_buf[15:8] <= wdata_i;
        cgcr_pkg::ADDR_PRI_LO: pri_buf[7:0] <= wdata_i;
        cgcr_pkg::ADDR_PRI_HI: pri_buf[9:8] <= wdata_i[1:0];
        cgcr_pkg::ADDR_SEC_LO: sec_buf[7:0] <= wdata_i;
        cgcr_pkg::ADDR_SEC_HI: sec_buf[9:8] <= wdata_i[1:0];
        cgcr_pkg::ADDR_TEST: test_buf <= wdata_i[5:0];
        default: ;
      endcase
    end
  end

  a_version_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_VER_LO && !spcfg[2])
    |=> ver_buf[7:0] == $past(wdata_i) && $stable(ver_buf[15:8]))
    else $error("version low byte not stored");
  a_primary_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_PRI_LO && !spcfg[2])
    |=> pri_buf[7:0] == $past(wdata_i) && $stable(pri_buf[9:8]))
    else $error("primary divider low byte wrong");
  a_secondary_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_SEC_HI && !spcfg[2])
    |=> sec_buf[9:8] == $past(wdata_i[1:0]) && $stable(sec_buf[7:0]))
    else $error("secondary divider high bits wrong");
  // soft reset wipes buffered values one cycle after the strobe
  a_soft_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    spcfg[2] |=> ver_buf == cgcr_pkg::RST_VER && pri_buf == cgcr_pkg::RST_DIV
      && sec_buf == cgcr_pkg::RST_DIV && test_buf == cgcr_pkg::RST_TEST)
    else $error("soft reset left buffered state");

  // active copies load on a transfer strobe
  always_ff @(posedge clk_i) begin
    if (!nrst_i || spcfg[2]) begin
      version_o <= cgcr_pkg::RST_VER;
      pri_div_o <= cgcr_pkg::RST_DIV;
      sec_div_o <= cgcr_pkg::RST_DIV;
      test_div_o <= cgcr_pkg::RST_TEST;
    end else if (transfer_i) begin
      version_o <= ver_buf;
      pri_div_o <= pri_buf;
      sec_div_o <= sec_buf;
      test_div_o <= test_buf;
    end
  end

  a_transfer_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (transfer_i && !spcfg[2]) |=> version_o == $past(ver_buf) && pri_div_o == $past(pri_buf)
      && sec_div_o == $past(sec_buf) && test_div_o == $past(test_buf))
    else $error("transfer did not load active values");
  a_active_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!transfer_i && !spcfg[2]) |=> $stable(pri_div_o) && $stable(sec_div_o)
      && $stable(version_o))
    else $error("active value moved without transfer");

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        cgcr_pkg::ADDR_SPCFG: rdata_o <= sp_byte;
        cgcr_pkg::ADDR_RBSEL: rdata_o <= {7'h00, rb_active};
        cgcr_pkg::ADDR_VER_LO: rdata_o <= rb_active ? version_o[7:0] : ver_buf[7:0];
        cgcr_pkg::ADDR_VER_HI: rdata_o <= rb_active ? version_o[15:8] : ver_buf[15:8];
        cgcr_pkg::ADDR_PRI_LO: rdata_o <= rb_active ? pri_div_o[7:0] : pri_buf[7:0];
        cgcr_pkg::ADDR_PRI_HI: rdata_o <= {6'h00, rb_active ? pri_div_o[9:8] : pri_buf[9:8]};
        cgcr_pkg::ADDR_SEC_LO: rdata_o <= rb_active ? sec_div_o[7:0] : sec_buf[7:0];
        cgcr_pkg::ADDR_SEC_HI: rdata_o <= {6'h00, rb_active ? sec_div_o[9:8] : sec_buf[9:8]};
        cgcr_pkg::ADDR_TEST: rdata_o <= {2'h0, rb_active ? test_div_o : test_buf};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // reserved positions and unmapped addresses always read as zero
  a_reserved_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_i == cgcr_pkg::ADDR_PRI_HI || addr_i == cgcr_pkg::ADDR_SEC_HI)
    |=> rdata_o[7:2] == 6'h00)
    else $error("divider reserved bits not zero");
  a_test_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_i == cgcr_pkg::ADDR_TEST) |=> rdata_o[7:6] == 2'h0)
    else $error("test divider reserved bits not zero");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !hit |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  assign soft_reset_o = spcfg[2];
  assign lsb_first_o = spcfg[1];
  assign sdo_active_o = spcfg[0];

  a_unmapped_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && !hit && !spcfg[2]) |=> $stable(pri_buf) && $stable(sec_buf) && $stable(ver_buf)
      && $stable(test_buf) && $stable(rb_active) && $stable(spcfg))
    else $error("unmapped write changed state");
  a_readback_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_i == cgcr_pkg::ADDR_PRI_LO && rb_active) |=> rdata_o == $past(pri_div_o[7:0]))
    else $error("readback did not return active value");
  a_readback_buf: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_i == cgcr_pkg::ADDR_SEC_LO && !rb_active) |=> rdata_o == $past(sec_buf[7:0]))
    else $error("readback did not return buffered value");
  a_version_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_VER_HI && !spcfg[2]) |=> ver_buf[15:8] == $past(wdata_i))
    else $error("version high byte not stored");
  a_primary_high: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_PRI_HI && !spcfg[2])
    |=> pri_buf[9:8] == $past(wdata_i[1:0]) && $stable(pri_buf[7:0]))
    else $error("primary divider high bits wrong");
  a_secondary_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_SEC_LO && !spcfg[2])
    |=> sec_buf[7:0] == $past(wdata_i) && $stable(sec_buf[9:8]))
    else $error("secondary divider low byte wrong");
  a_mirror_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_i == cgcr_pkg::ADDR_SPCFG) |=> rdata_o[7] == rdata_o[0] && rdata_o[6] == rdata_o[1])
    else $error("config byte not mirrored");
  a_i2c_lsb: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == cgcr_pkg::ADDR_SPCFG && i2c_mode_i) |=> $stable(lsb_first_o))
    else $error("i2c write changed bit order");
endmodule

// ==== test/clock_gen_control_regs_low_bench.sv ====
// self-checking bench for the clock generator control register bank
`timescale 1ns/100ps
module clock_gen_control_regs_low_bench;
  logic clk_i = 0, nrst_i = 0, wr_i = 0, i2c_mode_i = 0, transfer_i = 0, rd_p = 0, rd_d = 0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic soft_reset_o, lsb_first_o, sdo_active_o;
  logic [15:0] version_o;
  logic [9:0] pri_div_o, sec_div_o;
  logic [5:0] test_div_o;
  logic [7:0] expq [$];
  logic [7:0] shadow [0:8];
  logic [11:0] amap [0:8] = '{12'h000, 12'h004, 12'h005, 12'h006, 12'h010, 12'h011,
                              12'h012, 12'h013, 12'h014};
  int seed = 32'hd4be;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  cgcr_regs dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .i2c_mode_i(i2c_mode_i), .transfer_i(transfer_i), .rdata_o(rdata_o),
    .soft_reset_o(soft_reset_o), .lsb_first_o(lsb_first_o), .sdo_active_o(sdo_active_o),
    .version_o(version_o), .pri_div_o(pri_div_o), .sec_div_o(sec_div_o),
    .test_div_o(test_div_o));
  initial forever #2 clk_i = ~clk_i;
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk_i) begin wr_i <= 1; addr_i <= a; wdata_i <= d; end
    @(posedge clk_i) wr_i <= 0;
  endtask
  // the expected byte is queued; the monitor compares it once rdata_o has settled
  task rd(logic [11:0] a, logic [7:0] e);
    @(posedge clk_i) begin addr_i <= a; rd_p <= 1; expq.push_back(e); end
    @(posedge clk_i) rd_p <= 0;
  endtask
  task rd_all;
    for (int i = 0; i < 9; i++) rd(amap[i], shadow[i]);
  endtask
  always @(posedge clk_i) begin
    rd_d <= rd_p;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  always @(negedge clk_i) if (rd_d) cmp("rdata_o", expq.pop_front(), rdata_o);
  initial begin
    logic [7:0] d;
    for (int i = 0; i < 9; i++) shadow[i] = 8'h00;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1;
    rd_all;
    for (int i = 0; i < 9; i++) begin
      d = 8'($random(seed));
      // reserved bits go out as their zero default, soft reset kept clear here
      case (i)
        0: d = d & 8'hC3;
        1: d = 8'h00;
        5, 7: d = d & 8'h03;
        8: d = d & 8'h3F;
        default: ;
      endcase
      wr(amap[i], d);
      shadow[i] = (i == 0) ? {d[7] | d[0], d[6] | d[1], 4'h0, d[6] | d[1], d[7] | d[0]} : d;
    end
    rd_all;
    // probes stay off every listed register, the reserved ones included
    wr(12'h001, 8'hFF);
    wr(12'h00F, 8'hFF);
    wr(12'hFFF, 8'hFF);
    rd(12'h00F, 8'h00);
    rd_all;
    @(posedge clk_i) transfer_i <= 1;
    @(posedge clk_i) transfer_i <= 0;
    @(negedge clk_i);
    cmp("pri_div_o", {shadow[5][1:0], shadow[4]}, pri_div_o);
    cmp("sec_div_o", {shadow[7][1:0], shadow[6]}, sec_div_o);
    cmp("version_o", {shadow[3], shadow[2]}, version_o);
    cmp("test_div_o", shadow[8][5:0], test_div_o);
    cmp("sdo_active_o", shadow[0][0], sdo_active_o);
    cmp("lsb_first_o", shadow[0][1], lsb_first_o);
    wr(12'h004, 8'h01);
    wr(12'h010, ~shadow[4]);
    rd(12'h010, shadow[4]);
    shadow[4] = ~shadow[4];
    wr(12'h004, 8'h00);
    rd(12'h010, shadow[4]);
    wr(12'h000, 8'h24);
    @(negedge clk_i) cmp("soft_reset_o", 1'b1, soft_reset_o);
    @(negedge clk_i) cmp("soft_reset_o", 1'b0, soft_reset_o);
    repeat (2) @(negedge clk_i);
    cmp("pri_div_o", 10'h000, pri_div_o);
    rd(12'h010, 8'h00);
    // in i2c mode a soft reset write must leave the spi-only bits alone
    wr(12'h000, 8'h81);
    @(posedge clk_i) i2c_mode_i <= 1;
    wr(12'h000, 8'h24);
    rd(12'h000, 8'h81);
    i2c_mode_i <= 0;
    @(negedge clk_i) cmp("sdo_active_o", 1'b1, sdo_active_o);
    // mid-run reset must drop the readback select and the port config
    wr(12'h004, 8'h01);
    @(posedge clk_i) nrst_i <= 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    rd(12'h004, 8'h00);
    rd(12'h000, 8'h00);
    repeat (3) @(posedge clk_i);
    tally_and_finish;
  end
endmodule
